// *** verilog/dpc_pkg.sv ***
// constants and types shared by both ends of the digital pull control link
// Behaviour
// R1 - powers up nominal, factory range; host may change
// R2 - offset is 26-bit signed two's complement word
// R3 - control word resets to zero offset
// R4 - low 16 at 0x00, high 10 at 0x01
// R5 - new offset applied only on high-word write
// R6 - host writes low word before high word
// R7 - 4-bit range field at 0x02 selects sixteen ranges
// R8 - offset never exceeds selected range limits
// R9 - full positive half range is 2^25-1
// R10 - step per unit depends on selected range
// R11 - software enable bit only acts in software mode
// R12 - host sets enable bit in each high write
// R13 - frequency updates no faster than 38 kHz
// R14 - drive strength fields at 0x05 and 0x06
// R15 - control registers are 16 bits wide
// R16 - offset linear in word via fractional divider
// R17 - unused bits read zero, ignore writes
// R18 - software enable bit resets to disabled
// R19 - writable registers read back last written value
package dpc_pkg;
   // ***************************************************************
   // widths
   // ***************************************************************
   localparam int ADDR_W = 8; // register address width
   localparam int DATA_W = 16; // register width
   localparam int WORD_W = 26; // frequency control word width
   localparam int LOW_W = 16; // low word width
   localparam int HIGH_W = 10; // high word width
   localparam int RANGE_W = 4; // pull range field width
   localparam int DRIVE_W = 4; // drive strength field width
   localparam int GAP_W = 12; // update spacing counter width
   // ***************************************************************
   // device register map
   // ***************************************************************
   localparam logic [7:0] REG_FREQ_LOW = 8'h00; // freq_word_low
   localparam logic [7:0] REG_FREQ_HIGH = 8'h01; // freq_word_high_and_output_enable
   localparam logic [7:0] REG_PULL_RANGE = 8'h02; // pull_range_select
   localparam logic [7:0] REG_RISE_DRIVE = 8'h05; // rise_drive_strength
   localparam logic [7:0] REG_FALL_DRIVE = 8'h06; // fall_drive_strength
   localparam int OE_BIT = 10; // output enable bit in high register
   // ***************************************************************
   // reset values
   // ***************************************************************
   localparam logic [WORD_W-1:0] WORD_RST = 26'h0000000; // nominal frequency
   localparam logic [LOW_W-1:0] LOW_RST = 16'h0000; // low word after reset
   localparam logic [HIGH_W-1:0] HIGH_RST = 10'h000; // high word after reset
   localparam logic OE_RST = 1'b0; // output disabled
   localparam logic [DRIVE_W-1:0] DRIVE_RST = 4'h0; // drive strength after reset
   localparam logic [RANGE_W-1:0] RANGE_FACTORY = 4'h9; // factory range default
   localparam logic [DATA_W-1:0] DATA_ZERO = 16'h0000; // idle read data
   // ***************************************************************
   // word limits
   // ***************************************************************
   localparam logic [WORD_W-1:0] WORD_MOST_NEG = 26'h2000000; // -2^25, beyond range
   localparam logic [WORD_W-1:0] WORD_NEG_LIMIT = 26'h2000001; // -(2^25-1)
   localparam logic [WORD_W-1:0] WORD_POS_LIMIT = 26'h1FFFFFF; // 2^25-1 full half range
   // ***************************************************************
   // timing
   // ***************************************************************
   localparam int CLK_HZ = 100000000; // system clock rate
   localparam int UPD_RATE_HZ = 38000; // highest update rate
   localparam int UPD_GAP_CYC = (CLK_HZ + UPD_RATE_HZ - 1) / UPD_RATE_HZ; // least spacing
   localparam logic [GAP_W-1:0] GAP_LOAD = GAP_W'(UPD_GAP_CYC - 1); // counter load
   localparam logic [GAP_W-1:0] GAP_ZERO = 12'h000; // counter expired
   // ***************************************************************
   // host command registers
   // ***************************************************************
   localparam logic [7:0] HREG_TGT_LOW = 8'h00; // target word low 16
   localparam logic [7:0] HREG_TGT_HIGH = 8'h01; // target high 10 and enable bit 10
   localparam logic [7:0] HREG_CMD = 8'h02; // command strobes
   localparam logic [7:0] HREG_RAW_ADDR = 8'h03; // single access address
   localparam logic [7:0] HREG_RAW_WDATA = 8'h04; // single access write data
   localparam logic [7:0] HREG_STATUS = 8'h05; // busy and done flags
   localparam logic [7:0] HREG_RAW_RDATA = 8'h06; // single read result
   localparam int CMD_FREQ = 0; // send frequency word
   localparam int CMD_RAW_WR = 1; // single register write
   localparam int CMD_RAW_RD = 2; // single register read
   localparam int ST_BUSY = 0; // status: sequence running
   localparam int ST_DONE = 1; // status: read result ready
   // ***************************************************************
   // host sequencer states
   // ***************************************************************
   typedef enum logic [2:0] {HS_IDLE, HS_LOW, HS_HIGH, HS_GAP, HS_RAW_WR, HS_RAW_RD, HS_RAW_CAP} dpc_host_st_t;
endpackage : dpc_pkg

// *** verilog/dpc_if.sv ***
// register link between the host controller and the pull control registers
`timescale 1ns/1ns
interface dpc_if;
   logic [dpc_pkg::ADDR_W-1:0] addr; // register address
   logic [dpc_pkg::DATA_W-1:0] wdata; // write data
   logic wr; // one-cycle write strobe
   logic rd; // one-cycle read strobe
   logic [dpc_pkg::DATA_W-1:0] rdata; // read data, cycle after rd
   // host end drives the strobes
   modport host (output addr, output wdata, output wr, output rd, input rdata);
   // device end answers
   modport dev (input addr, input wdata, input wr, input rd, output rdata);
endinterface : dpc_if

// *** verilog/dpc_sync2.sv ***
// two flip-flop synchroniser for a level from outside the clock domain
`timescale 1ns/1ns
module dpc_sync2 (
   input wire logic clock,
   input wire logic rst,
   input wire logic async_in,
   output logic sync_out
);
   // ***************************************************************
   // state
   // ***************************************************************
   typedef struct packed {
      logic meta; // first stage, read only by second
      logic stab; // second stage
   } dpc_sync_t;
   dpc_sync_t s_q; // registered state
   dpc_sync_t s_d; // next state
   // shift the level through two stages
   always_comb begin
      s_d = s_q;
      s_d.meta = async_in;
      s_d.stab = s_q.meta;
   end
   // register the state
   always_ff @(posedge clock) begin
      if (rst) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end
   assign sync_out = s_q.stab;
endmodule : dpc_sync2

// *** verilog/dpc_host.sv ***
// host controller that sends frequency words and single accesses to the registers
`timescale 1ns/1ns
module dpc_host (
   input wire logic clock,
   input wire logic rst,
   dpc_if.host bus,
   input wire logic [7:0] sw_addr,
   input wire logic [15:0] sw_wdata,
   input wire logic sw_wr,
   input wire logic sw_rd,
   output logic [15:0] sw_rdata
);
   // ***************************************************************
   // state
   // ***************************************************************
   typedef struct packed {
      dpc_pkg::dpc_host_st_t st; // sequencer state
      logic [dpc_pkg::LOW_W-1:0] tgt_low; // target word low part
      logic [dpc_pkg::HIGH_W-1:0] tgt_high; // target word high part
      logic tgt_oe; // enable bit sent with high word
      logic [dpc_pkg::ADDR_W-1:0] raw_addr; // single access address
      logic [dpc_pkg::DATA_W-1:0] raw_wdata; // single access data
      logic [dpc_pkg::DATA_W-1:0] raw_rdata; // single read result
      logic done; // sticky read done
      logic [dpc_pkg::GAP_W-1:0] gap; // update spacing count
      logic [dpc_pkg::ADDR_W-1:0] addr; // bus address
      logic [dpc_pkg::DATA_W-1:0] wdata; // bus write data
      logic wr; // bus write strobe
      logic rd; // bus read strobe
      logic [15:0] sw_rdata; // software read data
   } dpc_host_t;
   dpc_host_t s_q; // registered state
   dpc_host_t s_d; // next state
   logic idle; // sequencer free
   // ***************************************************************
   // next state
   // ***************************************************************
   always_comb begin
      s_d = s_q;
      idle = (s_q.st == dpc_pkg::HS_IDLE);
      s_d.wr = 1'b0;
      s_d.rd = 1'b0;
      s_d.sw_rdata = 16'h0000;
      // software writes to own registers
      if (sw_wr) begin
         if (sw_addr == dpc_pkg::HREG_TGT_LOW) begin
            s_d.tgt_low = sw_wdata;
         end else if (sw_addr == dpc_pkg::HREG_TGT_HIGH) begin
            s_d.tgt_high = sw_wdata[dpc_pkg::HIGH_W-1:0];
            s_d.tgt_oe = sw_wdata[dpc_pkg::OE_BIT];
         end else if (sw_addr == dpc_pkg::HREG_RAW_ADDR) begin
            s_d.raw_addr = sw_wdata[dpc_pkg::ADDR_W-1:0];
         end else if (sw_addr == dpc_pkg::HREG_RAW_WDATA) begin
            s_d.raw_wdata = sw_wdata;
         end else if (sw_addr == dpc_pkg::HREG_STATUS) begin
            // write one to clear done
            if (sw_wdata[dpc_pkg::ST_DONE]) begin
               s_d.done = 1'b0;
            end
         end
      end
      // software reads, answer next cycle
      if (sw_rd) begin
         if (sw_addr == dpc_pkg::HREG_TGT_LOW) begin
            s_d.sw_rdata = s_q.tgt_low;
         end else if (sw_addr == dpc_pkg::HREG_TGT_HIGH) begin
            s_d.sw_rdata = {5'h00, s_q.tgt_oe, s_q.tgt_high};
         end else if (sw_addr == dpc_pkg::HREG_RAW_ADDR) begin
            s_d.sw_rdata = {8'h00, s_q.raw_addr};
         end else if (sw_addr == dpc_pkg::HREG_RAW_WDATA) begin
            s_d.sw_rdata = s_q.raw_wdata;
         end else if (sw_addr == dpc_pkg::HREG_STATUS) begin
            s_d.sw_rdata = {14'h0000, s_q.done, ~idle};
         end else if (sw_addr == dpc_pkg::HREG_RAW_RDATA) begin
            s_d.sw_rdata = s_q.raw_rdata;
         end
      end
      // sequencer
      case (s_q.st)
         dpc_pkg::HS_IDLE: begin
            // commands while busy are ignored
            if (sw_wr && sw_addr == dpc_pkg::HREG_CMD) begin
               if (sw_wdata[dpc_pkg::CMD_FREQ]) begin
                  s_d.addr = dpc_pkg::REG_FREQ_LOW; // R6
                  s_d.wdata = s_q.tgt_low;
                  s_d.wr = 1'b1;
                  s_d.st = dpc_pkg::HS_LOW;
               end else if (sw_wdata[dpc_pkg::CMD_RAW_WR]) begin
                  s_d.addr = s_q.raw_addr;
                  s_d.wdata = s_q.raw_wdata;
                  s_d.wr = 1'b1;
                  s_d.st = dpc_pkg::HS_RAW_WR;
               end else if (sw_wdata[dpc_pkg::CMD_RAW_RD]) begin
                  s_d.addr = s_q.raw_addr;
                  s_d.rd = 1'b1;
                  s_d.st = dpc_pkg::HS_RAW_RD;
               end
            end
         end
         dpc_pkg::HS_LOW: begin
            // high word last, carrying the enable bit
            s_d.addr = dpc_pkg::REG_FREQ_HIGH; // R6
            s_d.wdata = {5'h00, s_q.tgt_oe, s_q.tgt_high}; // R12
            s_d.wr = 1'b1;
            s_d.st = dpc_pkg::HS_HIGH;
         end
         dpc_pkg::HS_HIGH: begin
            s_d.gap = dpc_pkg::GAP_LOAD; // R13
            s_d.st = dpc_pkg::HS_GAP;
         end
         dpc_pkg::HS_GAP: begin
            // hold off the next command until spacing expires
            if (s_q.gap == dpc_pkg::GAP_ZERO) begin
               s_d.st = dpc_pkg::HS_IDLE; // R13
            end else begin
               s_d.gap = s_q.gap - 12'h001;
            end
         end
         dpc_pkg::HS_RAW_WR: begin
            s_d.st = dpc_pkg::HS_IDLE;
         end
         dpc_pkg::HS_RAW_RD: begin
            s_d.st = dpc_pkg::HS_RAW_CAP;
         end
         dpc_pkg::HS_RAW_CAP: begin
            // capture answer; set wins over clear
            s_d.raw_rdata = bus.rdata;
            s_d.done = 1'b1;
            s_d.st = dpc_pkg::HS_IDLE;
         end
         default: begin
            s_d.st = dpc_pkg::HS_IDLE;
         end
      endcase
   end
   // register the state
   always_ff @(posedge clock) begin
      if (rst) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end
   // ***************************************************************
   // outputs
   // ***************************************************************
   assign bus.addr = s_q.addr;
   assign bus.wdata = s_q.wdata;
   assign bus.wr = s_q.wr;
   assign bus.rd = s_q.rd;
   assign sw_rdata = s_q.sw_rdata;
endmodule : dpc_host

// *** verilog/dpc_dev.sv ***
// pull control register bank with atomic frequency word and update pacing
`timescale 1ns/1ns
module dpc_dev #(
   parameter logic [3:0] FACTORY_RANGE = dpc_pkg::RANGE_FACTORY, // range after power-up
   parameter logic SW_OE_CTRL = 1'b1 // 1: software enable, 0: enable pin
) (
   input wire logic clock,
   input wire logic rst,
   dpc_if.dev bus,
   input wire logic oe_pin,
   output logic [25:0] div_offset,
   output logic div_update,
   output logic [3:0] pull_range,
   output logic out_enable,
   output logic [3:0] rise_drive,
   output logic [3:0] fall_drive
);
   // ***************************************************************
   // state
   // ***************************************************************
   typedef struct packed {
      logic [dpc_pkg::LOW_W-1:0] low; // stored low word
      logic [dpc_pkg::HIGH_W-1:0] high; // stored high word
      logic oe_bit; // software enable bit
      logic [dpc_pkg::RANGE_W-1:0] range; // pull range select
      logic [dpc_pkg::DRIVE_W-1:0] rise; // rising drive strength
      logic [dpc_pkg::DRIVE_W-1:0] fall; // falling drive strength
      logic [dpc_pkg::WORD_W-1:0] pend_word; // word awaiting apply
      logic pend; // an update waits for spacing
      logic [dpc_pkg::GAP_W-1:0] gap; // spacing since last apply
      logic [dpc_pkg::WORD_W-1:0] offset; // applied divider offset
      logic update; // one-cycle apply pulse
      logic out_en; // driver enable
      logic [dpc_pkg::DATA_W-1:0] rdata; // read answer
   } dpc_dev_t;
   dpc_dev_t s_q; // registered state
   dpc_dev_t s_d; // next state
   logic pin_sync; // synchronised enable pin
   logic [dpc_pkg::WORD_W-1:0] new_word; // word formed on high write
   logic high_wr; // high word write this cycle
   // ***************************************************************
   // enable pin synchroniser
   // ***************************************************************
   dpc_sync2 dpc_sync2_i (
      .clock(clock),
      .rst(rst),
      .async_in(oe_pin),
      .sync_out(pin_sync)
   );
   // ***************************************************************
   // next state
   // ***************************************************************
   always_comb begin
      s_d = s_q;
      high_wr = bus.wr && (bus.addr == dpc_pkg::REG_FREQ_HIGH);
      // stored low combined with new high, signed word
      new_word = {bus.wdata[dpc_pkg::HIGH_W-1:0], s_q.low}; // R2 R4 R5
      s_d.update = 1'b0;
      s_d.rdata = dpc_pkg::DATA_ZERO;
      // register writes, unused bits dropped
      if (bus.wr) begin
         if (bus.addr == dpc_pkg::REG_FREQ_LOW) begin
            // low word alone changes nothing
            s_d.low = bus.wdata; // R4 R5
         end else if (bus.addr == dpc_pkg::REG_FREQ_HIGH) begin
            s_d.high = bus.wdata[dpc_pkg::HIGH_W-1:0]; // R4
            // bit ignored under pin control
            if (SW_OE_CTRL) begin
               s_d.oe_bit = bus.wdata[dpc_pkg::OE_BIT]; // R11
            end
         end else if (bus.addr == dpc_pkg::REG_PULL_RANGE) begin
            s_d.range = bus.wdata[dpc_pkg::RANGE_W-1:0]; // R7 R1
         end else if (bus.addr == dpc_pkg::REG_RISE_DRIVE) begin
            s_d.rise = bus.wdata[dpc_pkg::DRIVE_W-1:0]; // R14
         end else if (bus.addr == dpc_pkg::REG_FALL_DRIVE) begin
            s_d.fall = bus.wdata[dpc_pkg::DRIVE_W-1:0]; // R14 R17
         end
      end
      // reads return last written values, zeros elsewhere
      if (bus.rd) begin
         if (bus.addr == dpc_pkg::REG_FREQ_LOW) begin
            s_d.rdata = s_q.low; // R19 R15
         end else if (bus.addr == dpc_pkg::REG_FREQ_HIGH) begin
            s_d.rdata = {5'h00, s_q.oe_bit, s_q.high}; // R19 R17
         end else if (bus.addr == dpc_pkg::REG_PULL_RANGE) begin
            s_d.rdata = {12'h000, s_q.range}; // R19 R17
         end else if (bus.addr == dpc_pkg::REG_RISE_DRIVE) begin
            s_d.rdata = {12'h000, s_q.rise}; // R17
         end else if (bus.addr == dpc_pkg::REG_FALL_DRIVE) begin
            s_d.rdata = {12'h000, s_q.fall}; // R17
         end else begin
            // unmapped address reads zero
            s_d.rdata = dpc_pkg::DATA_ZERO; // R17
         end
      end
      // spacing counter runs down after each apply
      if (s_q.gap != dpc_pkg::GAP_ZERO) begin
         s_d.gap = s_q.gap - 12'h001; // R13
      end
      // apply a waiting word once spacing has run out
      if (s_q.pend && s_q.gap == dpc_pkg::GAP_ZERO) begin
         // the one code beyond the range is held at the limit
         if (s_q.pend_word == dpc_pkg::WORD_MOST_NEG) begin
            s_d.offset = dpc_pkg::WORD_NEG_LIMIT; // R8
         end else begin
            // passed straight to the divider, offset linear in word
            s_d.offset = s_q.pend_word; // R16 R9 R10
         end
         s_d.update = 1'b1; // R5
         s_d.pend = 1'b0;
         s_d.gap = dpc_pkg::GAP_LOAD; // R13
      end
      // a high write forms the new word; latest one wins
      if (high_wr) begin
         s_d.pend_word = new_word; // R5
         s_d.pend = 1'b1; // R13
      end
      // driver enable follows the selected source
      if (SW_OE_CTRL) begin
         s_d.out_en = s_q.oe_bit; // R11 R18
      end else begin
         s_d.out_en = pin_sync; // R11
      end
   end
   // ***************************************************************
   // register the state
   // ***************************************************************
   always_ff @(posedge clock) begin
      if (rst) begin
         // nominal frequency, factory range, output off
         s_q.low <= dpc_pkg::LOW_RST; // R3
         s_q.high <= dpc_pkg::HIGH_RST; // R3
         s_q.oe_bit <= dpc_pkg::OE_RST; // R18
         s_q.range <= FACTORY_RANGE; // R1
         s_q.rise <= dpc_pkg::DRIVE_RST;
         s_q.fall <= dpc_pkg::DRIVE_RST;
         s_q.pend_word <= dpc_pkg::WORD_RST;
         s_q.pend <= 1'b0;
         s_q.gap <= dpc_pkg::GAP_ZERO;
         s_q.offset <= dpc_pkg::WORD_RST; // R1 R3
         s_q.update <= 1'b0;
         s_q.out_en <= dpc_pkg::OE_RST; // R18
         s_q.rdata <= dpc_pkg::DATA_ZERO;
      end else begin
         s_q <= s_d;
      end
   end
   // ***************************************************************
   // outputs
   // ***************************************************************
   assign div_offset = s_q.offset; // applied word to the divider
   assign div_update = s_q.update; // apply pulse
   assign pull_range = s_q.range; // selected range
   assign out_enable = s_q.out_en; // output driver enable
   assign rise_drive = s_q.rise; // rising drive strength
   assign fall_drive = s_q.fall; // falling drive strength
   assign bus.rdata = s_q.rdata; // read answer
endmodule : dpc_dev

// *** verification/dpc_monitor.sv ***
// checker watching the host to register link
`timescale 1ns/1ns
module dpc_monitor #(
   parameter logic [3:0] FACTORY_RANGE = 4'h9
) (
   input wire logic clock,
   input wire logic rst,
   input wire logic [7:0] addr,
   input wire logic [15:0] wdata,
   input wire logic wr,
   input wire logic rd,
   input wire logic [15:0] rdata
);
   // ************************************************
   // shadow of the last written values
   // ************************************************
   logic [15:0] lo_q; // low word
   logic [10:0] hi_q; // high word and enable bit
   logic [3:0] rg_q; // pull range
   logic [3:0] ru_q; // rise drive
   logic [3:0] rf_q; // fall drive
   // shadows follow every write strobe
   always_ff @(posedge clock) begin
      if (rst) begin
         lo_q <= 16'h0000;
         hi_q <= 11'h000;
         rg_q <= FACTORY_RANGE;
         ru_q <= 4'h0;
         rf_q <= 4'h0;
      end else if (wr) begin
         if (addr == 8'h00) lo_q <= wdata;
         if (addr == 8'h01) hi_q <= wdata[10:0];
         if (addr == 8'h02) rg_q <= wdata[3:0];
         if (addr == 8'h05) ru_q <= wdata[3:0];
         if (addr == 8'h06) rf_q <= wdata[3:0];
      end
   end
   // ************************************************
   // properties
   // ************************************************
   default clocking cb @(posedge clock); endclocking
   default disable iff (rst);
   property p_excl; !(wr && rd); endproperty
   property p_idle; !$past(rd) |-> rdata == 16'h0000; endproperty
   property p_unmap; $past(rd) && !($past(addr) inside {8'h00, 8'h01, 8'h02, 8'h05, 8'h06}) |-> rdata == 16'h0000;
   endproperty
   property p_low; $past(rd) && $past(addr) == 8'h00 |-> rdata == lo_q; endproperty
   property p_high; $past(rd) && $past(addr) == 8'h01 |-> rdata == {5'h00, hi_q}; endproperty
   property p_range; $past(rd) && $past(addr) == 8'h02 |-> rdata == {12'h000, rg_q}; endproperty
   property p_rise; $past(rd) && $past(addr) == 8'h05 |-> rdata == {12'h000, ru_q}; endproperty
   property p_fall; $past(rd) && $past(addr) == 8'h06 |-> rdata == {12'h000, rf_q}; endproperty
   a_excl: assert property (p_excl) else $error("write and read strobes together");
   a_idle: assert property (p_idle) else $error("read data outside answer cycle");
   a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
   a_low: assert property (p_low) else $error("low word readback wrong");
   a_high: assert property (p_high) else $error("high word readback wrong");
   a_range: assert property (p_range) else $error("range readback wrong");
   a_rise: assert property (p_rise) else $error("rise drive readback wrong");
   a_fall: assert property (p_fall) else $error("fall drive readback wrong");
   c_high: cover property (wr && addr == 8'h01);
   c_low: cover property (rd && addr == 8'h00);
   c_unmap: cover property (rd && addr == 8'h03);
endmodule : dpc_monitor

// *** verification/dpc_tb.sv ***
// bench joining host controller and pull control registers
`timescale 1ns/1ns
module dpc_tb;
   logic clock = 1'b0;
   logic rst = 1'b1;
   logic [7:0] sw_addr = 8'h00;
   logic [15:0] sw_wdata = 16'h0000;
   logic sw_wr = 1'b0;
   logic sw_rd = 1'b0;
   logic [15:0] sw_rdata;
   logic [25:0] div_offset;
   logic div_update;
   logic [3:0] pull_range;
   logic [3:0] rise_drive;
   logic [3:0] fall_drive;
   logic out_enable;
   logic oe_pin = 1'b0;
   int miscompares = 0;
   int tests_run = 0;
   int n;
   logic [15:0] rv;
   dpc_if bus_i ();
   dpc_host dpc_host_i (.clock(clock), .rst(rst), .bus(bus_i.host), .sw_addr(sw_addr), .sw_wdata(sw_wdata),
      .sw_wr(sw_wr), .sw_rd(sw_rd), .sw_rdata(sw_rdata));
   dpc_dev dpc_dev_i (.clock(clock), .rst(rst), .bus(bus_i.dev), .oe_pin(oe_pin), .div_offset(div_offset),
      .div_update(div_update), .pull_range(pull_range), .out_enable(out_enable), .rise_drive(rise_drive),
      .fall_drive(fall_drive));
   dpc_monitor #(.FACTORY_RANGE(dpc_pkg::RANGE_FACTORY)) dpc_monitor_i (.clock(clock), .rst(rst),
      .addr(bus_i.addr), .wdata(bus_i.wdata), .wr(bus_i.wr), .rd(bus_i.rd), .rdata(bus_i.rdata));
   // free running clock
   always #5 clock = ~clock;
   // ************************************************
   // shared tasks
   // ************************************************
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         miscompares++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check
   task automatic tally_and_finish;
      $display("comparisons %0d mismatches %0d", tests_run, miscompares);
      if (miscompares == 0 && tests_run > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : tally_and_finish
   // one software write, strobe dropped on the next edge
   task automatic sw_wrt(input logic [7:0] a, input logic [15:0] d);
      @(posedge clock);
      sw_addr <= a;
      sw_wdata <= d;
      sw_wr <= 1'b1;
      @(posedge clock);
      sw_wr <= 1'b0;
   endtask : sw_wrt
   // one software read, data taken in the answer cycle
   task automatic sw_rdd(input logic [7:0] a, output logic [15:0] d);
      @(posedge clock);
      sw_addr <= a;
      sw_rd <= 1'b1;
      @(posedge clock);
      sw_rd <= 1'b0;
      #1 d = sw_rdata;
   endtask : sw_rdd
   // poll busy flag, bounded
   task automatic wait_idle;
      for (int i = 0; i < 2000; i++) begin
         sw_rdd(8'h05, rv);
         if (rv[0] === 1'b0) return;
      end
      miscompares++;
      tally_and_finish();
   endtask : wait_idle
   // count cycles until the next applied word, bounded
   task automatic wait_upd(output int c);
      for (c = 0; c < 3000; c++) begin
         @(posedge clock);
         #1;
         if (div_update === 1'b1) return;
      end
      miscompares++;
      tally_and_finish();
   endtask : wait_upd
   // single device write and read through the host
   task automatic dev_wr(input logic [7:0] a, input logic [15:0] d);
      sw_wrt(8'h03, {8'h00, a});
      sw_wrt(8'h04, d);
      sw_wrt(8'h02, 16'h0002);
   endtask : dev_wr
   task automatic dev_rd(input logic [7:0] a, output logic [15:0] d);
      sw_wrt(8'h03, {8'h00, a});
      sw_wrt(8'h02, 16'h0004);
      wait_idle();
      sw_rdd(8'h06, d);
   endtask : dev_rd
   // ************************************************
   // scenarios
   // ************************************************
   initial begin
      repeat (16) @(posedge clock);
      rst <= 1'b0;
      // pin raised while software owns the enable
      oe_pin <= 1'b1;
      @(posedge clock);
      #1;
      check(div_offset, 26'h0000000);
      check(pull_range, dpc_pkg::RANGE_FACTORY);
      check({out_enable, rise_drive, fall_drive}, 9'h000);
      dev_rd(8'h01, rv);
      check(rv, 16'h0000);
      check(out_enable, 1'b0);
      // plus 90 of 200 word sent low then high
      sw_wrt(8'h00, 16'h6666);
      sw_wrt(8'h01, 16'h04E6);
      sw_wrt(8'h02, 16'h0001);
      wait_upd(n);
      @(posedge clock);
      #1;
      check(div_offset, 26'h0E66666);
      check(out_enable, 1'b1);
      wait_idle();
      // low word alone applies nothing
      dev_wr(8'h00, 16'h0000);
      repeat (8) @(posedge clock);
      check(div_offset, 26'h0E66666);
      dev_rd(8'h00, rv);
      check(rv, 16'h0000);
      // most negative code clamps, second high write paced
      dev_wr(8'h01, 16'hFE00);
      wait_upd(n);
      #1;
      check(div_offset, 26'h2000001);
      dev_wr(8'h01, 16'hFCFF);
      wait_upd(n);
      check(n > dpc_pkg::UPD_GAP_CYC - 20 && n <= dpc_pkg::UPD_GAP_CYC, 1'b1);
      check(div_offset, 26'h0FF0000);
      dev_rd(8'h01, rv);
      check(rv, 16'h04FF);
      // every pull range code
      for (int r = 0; r < 16; r++) begin
         dev_wr(8'h02, 16'hFFF0 | 16'(r));
         repeat (4) @(posedge clock);
         check(pull_range, r[3:0]);
      end
      dev_wr(8'h05, 16'hFFF5);
      dev_wr(8'h06, 16'hFFFA);
      repeat (4) @(posedge clock);
      check({rise_drive, fall_drive}, 8'h5A);
      dev_rd(8'h02, rv);
      check(rv, 16'h000F);
      dev_rd(8'h06, rv);
      check(rv, 16'h000A);
      // unmapped place ignores writes
      dev_wr(8'h03, 16'hFFFF);
      dev_rd(8'h03, rv);
      check(rv, 16'h0000);
      // done flag set by the last read, cleared by writing one
      sw_rdd(8'h05, rv);
      check(rv, 16'h0002);
      sw_wrt(8'h05, 16'h0002);
      sw_rdd(8'h05, rv);
      check(rv, 16'h0000);
      tally_and_finish();
   end
endmodule : dpc_tb
